//--- design/txcds_regs.svh
// register map, field positions, reset values and timing counts of the tx clock/data source selector
`ifndef TXCDS_REGS_SVH
`define TXCDS_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define TXCDS_OFF_CTRL 8'h00
`define TXCDS_OFF_ICLK_DIV 8'h04
`define TXCDS_OFF_BR_DIV 8'h08
`define TXCDS_OFF_STATUS 8'h0C
`define TXCDS_OFF_RATE 8'h10

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define TXCDS_CTRL_RF_EN 0
`define TXCDS_CTRL_CSS 1
`define TXCDS_CTRL_CFM 2
`define TXCDS_CTRL_BRM 3
`define TXCDS_CTRL_ACE 4
`define TXCDS_CTRL_DSS 5
`define TXCDS_CTRL_IDS_LO 6
`define TXCDS_CTRL_IDS_HI 7
`define TXCDS_CTRL_W 8

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define TXCDS_STAT_CLK_PRES 0
`define TXCDS_STAT_DAT_PRES 1
`define TXCDS_STAT_MODE_LO 2
`define TXCDS_STAT_MODE_HI 3
`define TXCDS_STAT_EST_OK 4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TXCDS_RST_CTRL 8'h00
`define TXCDS_RST_ICLK_DIV 16'h0010
`define TXCDS_RST_BR_DIV 16'h0010
`define TXCDS_RST_LFSR 9'h1FF

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define TXCDS_CLK_PERIOD_NS 40
`define TXCDS_ACT_TIMEOUT_NS 20000
`define TXCDS_ACT_TIMEOUT_CYC ((`TXCDS_ACT_TIMEOUT_NS + `TXCDS_CLK_PERIOD_NS - 1) / `TXCDS_CLK_PERIOD_NS)
`define TXCDS_MIN_PERIOD 2

`endif

//--- design/txcds_pkg.sv
// types shared by the tx clock/data source selector
package txcds_pkg;
	// what the rf stage is told to do
	typedef enum logic [1:0] {
		TXCDS_RF_OFF,
		TXCDS_RF_CARRIER,
		TXCDS_RF_MOD
	} txcds_rf_mode_t;

	// internal data patterns
	typedef enum logic [1:0] {
		TXCDS_IDS_ZERO,
		TXCDS_IDS_ONE,
		TXCDS_IDS_ALT,
		TXCDS_IDS_PRBS
	} txcds_int_data_t;
endpackage : txcds_pkg

//--- design/txcds_act.sv
// pin synchroniser with edge detect and timeout activity detector
`timescale 1ns/1ns
`include "txcds_regs.svh"
module txcds_act #(
	parameter int TIMEOUT_CYC = `TXCDS_ACT_TIMEOUT_CYC
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic pin_i,
	output logic level_o,
	output logic rise_o,
	output logic edge_o,
	output logic present_o
);
	import txcds_pkg::*;

	localparam int CW = $clog2(TIMEOUT_CYC + 1);

	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (TIMEOUT_CYC < 2) begin : g_bad_timeout
		$error("txcds_act: timeout below two cycles");
	end

	logic s1_r, s2_r, s3_r;
	logic [CW-1:0] idle_r, idle_nxt;
	logic pres_r, pres_nxt;

	// two-flop synchroniser, third flop only for edge finding
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign level_o = s2_r;
	assign rise_o = s2_r & ~s3_r;
	assign edge_o = s2_r ^ s3_r;

	// idle counter; any edge restarts it and marks the input present
	always_comb begin
		idle_nxt = idle_r;
		pres_nxt = pres_r;
		if (edge_o) begin
			idle_nxt = '0;
			pres_nxt = 1'b1;
		end else if (idle_r < CW'(TIMEOUT_CYC)) begin
			idle_nxt = idle_r + CW'(1);
		end else begin
			pres_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			idle_r <= '0;
			pres_r <= 1'b0;
		end else begin
			idle_r <= idle_nxt;
			pres_r <= pres_nxt;
		end
	end

	assign present_o = pres_r;

	a_act_timeout: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(idle_r == CW'(TIMEOUT_CYC) && !edge_o) |=> !present_o)
		else $error("input still present after idle timeout");

	a_act_edge: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		edge_o |=> (present_o && idle_r == '0))
		else $error("edge did not mark input present");
endmodule : txcds_act

//--- design/txcds_bitgen.sv
// bit strobe generator with programmable period and mid-bit resync
`timescale 1ns/1ns
`include "txcds_regs.svh"
module txcds_bitgen #(
	parameter int DIV_W = 16
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [DIV_W-1:0] period_i,
	input wire logic resync_i,
	output logic stb_o
);
	import txcds_pkg::*;

	logic [DIV_W-1:0] cnt_r, cnt_nxt;
	logic stb_r, stb_nxt;
	logic [DIV_W-1:0] per_eff;

	// periods below the minimum would strobe every cycle without a gap
	assign per_eff = (period_i < DIV_W'(`TXCDS_MIN_PERIOD)) ? DIV_W'(`TXCDS_MIN_PERIOD) : period_i;

	// count down; resync lands the next strobe half a bit later, mid-bit
	always_comb begin
		cnt_nxt = cnt_r;
		stb_nxt = 1'b0;
		if (resync_i) begin
			cnt_nxt = per_eff >> 1;
		end else if (cnt_r <= DIV_W'(1)) begin
			cnt_nxt = per_eff;
			stb_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r - DIV_W'(1);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			cnt_r <= '0;
			stb_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			stb_r <= stb_nxt;
		end
	end

	assign stb_o = stb_r;

	a_stb_gap: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(stb_r && !resync_i) |=> !stb_r)
		else $error("bit strobes closer than two cycles");
endmodule : txcds_bitgen

//--- design/txcds_top.sv
// tx clock/data source selector: ahb-lite registers, presence detect, rf mode and bit output
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`include "txcds_regs.svh"
module txcds_top #(
	parameter int DIV_W = 16,
	parameter int TIMEOUT_CYC = `TXCDS_ACT_TIMEOUT_CYC
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic [31:0] hrdata_o,
	output logic hresp_o,
	input wire logic ext_clk_i,
	input wire logic ext_data_i,
	output logic rf_on_o,
	output logic modulate_o,
	output logic tx_bit_o,
	output logic bit_strobe_o,
	output txcds_pkg::txcds_rf_mode_t rf_mode_o
);
	import txcds_pkg::*;

	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (DIV_W < 4 || DIV_W > 24) begin : g_bad_div
		$error("txcds_top: DIV_W must lie in 4..24");
	end

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic ap_valid;
	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] wr_addr_r, wr_addr_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic [`TXCDS_CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [DIV_W-1:0] iclk_div_r, iclk_div_nxt;
	logic [DIV_W-1:0] br_div_r, br_div_nxt;
	logic [31:0] status_word;

	logic clk_lvl, clk_rise, clk_edge, clk_pres;
	logic dat_lvl, dat_rise, dat_edge, dat_pres;

	logic [DIV_W-1:0] ivl_r, ivl_nxt;
	logic [DIV_W-1:0] est_r, est_nxt;
	logic est_ok_r, est_ok_nxt;
	logic seen_r, seen_nxt;

	logic [DIV_W-1:0] period_sel;
	logic gen_resync, gen_stb;

	logic [8:0] lfsr_r, lfsr_nxt;
	logic alt_r, alt_nxt;
	logic pat_bit;

	txcds_rf_mode_t mode_r, mode_nxt;
	logic rf_on_r, rf_on_nxt;
	logic mod_r, mod_nxt;
	logic tx_bit_r, tx_bit_nxt;
	logic stb_r, stb_nxt;

	logic c_rf, c_css, c_cfm, c_brm, c_ace;
	txcds_int_data_t c_ids;
	logic sel_auto, sel_manual, sel_extclk;

	assign c_rf = ctrl_r[`TXCDS_CTRL_RF_EN];
	assign c_css = ctrl_r[`TXCDS_CTRL_CSS];
	assign c_cfm = ctrl_r[`TXCDS_CTRL_CFM];
	assign c_brm = ctrl_r[`TXCDS_CTRL_BRM];
	assign c_ace = ctrl_r[`TXCDS_CTRL_ACE];
	assign c_ids = txcds_int_data_t'(ctrl_r[`TXCDS_CTRL_IDS_HI:`TXCDS_CTRL_IDS_LO]);

	// external-source sub-modes, mutually exclusive
	assign sel_auto = !c_css && !c_cfm && !c_brm;
	assign sel_manual = !c_css && !c_cfm && c_brm;
	assign sel_extclk = !c_css && c_cfm;

	// ------------------------------------------------------------
	// ahb-lite slave
	// ------------------------------------------------------------
	// zero wait states; hsize is ignored since only whole words are served
	assign ap_valid = hsel_i && htrans_i[1] && hready_i;

	// status bits gathered for reads
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`TXCDS_STAT_CLK_PRES] = clk_pres;
		status_word[`TXCDS_STAT_DAT_PRES] = dat_pres;
		status_word[`TXCDS_STAT_MODE_HI:`TXCDS_STAT_MODE_LO] = mode_r;
		status_word[`TXCDS_STAT_EST_OK] = est_ok_r;
	end

	// write lands in the data phase; reads see the _nxt values so a read straight
	// after a write to the same register returns the new word
	always_comb begin
		wr_pend_nxt = ap_valid && hwrite_i;
		wr_addr_nxt = ap_valid ? haddr_i[7:0] : wr_addr_r;
		ctrl_nxt = ctrl_r;
		iclk_div_nxt = iclk_div_r;
		br_div_nxt = br_div_r;
		hrdata_nxt = hrdata_r;
		if (wr_pend_r) begin
			unique case (wr_addr_r)
				`TXCDS_OFF_CTRL: ctrl_nxt = hwdata_i[`TXCDS_CTRL_W-1:0];
				`TXCDS_OFF_ICLK_DIV: iclk_div_nxt = hwdata_i[DIV_W-1:0];
				`TXCDS_OFF_BR_DIV: br_div_nxt = hwdata_i[DIV_W-1:0];
				default: ctrl_nxt = ctrl_r; // read-only or unmapped: ignored
			endcase
		end
		if (ap_valid && !hwrite_i) begin
			unique case (haddr_i[7:0])
				`TXCDS_OFF_CTRL: hrdata_nxt = {{(32-`TXCDS_CTRL_W){1'b0}}, ctrl_nxt};
				`TXCDS_OFF_ICLK_DIV: hrdata_nxt = {{(32-DIV_W){1'b0}}, iclk_div_nxt};
				`TXCDS_OFF_BR_DIV: hrdata_nxt = {{(32-DIV_W){1'b0}}, br_div_nxt};
				`TXCDS_OFF_STATUS: hrdata_nxt = status_word;
				`TXCDS_OFF_RATE: hrdata_nxt = {{(32-DIV_W){1'b0}}, est_r};
				default: hrdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
			ctrl_r <= `TXCDS_RST_CTRL;
			iclk_div_r <= DIV_W'(`TXCDS_RST_ICLK_DIV);
			br_div_r <= DIV_W'(`TXCDS_RST_BR_DIV);
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			hrdata_r <= hrdata_nxt;
			ctrl_r <= ctrl_nxt;
			iclk_div_r <= iclk_div_nxt;
			br_div_r <= br_div_nxt;
		end
	end

	// ready and response never change, but still come from flops
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end

	assign hrdata_o = hrdata_r;

	// ------------------------------------------------------------
	// external pin presence
	// ------------------------------------------------------------
	txcds_act #(
		.TIMEOUT_CYC(TIMEOUT_CYC)
	) u_clk_act (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.pin_i(ext_clk_i),
		.level_o(clk_lvl),
		.rise_o(clk_rise),
		.edge_o(clk_edge),
		.present_o(clk_pres)
	);

	txcds_act #(
		.TIMEOUT_CYC(TIMEOUT_CYC)
	) u_dat_act (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.pin_i(ext_data_i),
		.level_o(dat_lvl),
		.rise_o(dat_rise),
		.edge_o(dat_edge),
		.present_o(dat_pres)
	);

	// ------------------------------------------------------------
	// automatic rate estimate
	// ------------------------------------------------------------
	// shortest gap between data edges is one bit; a glitch drags the estimate
	// down until the data goes quiet long enough to time out
	always_comb begin
		ivl_nxt = (ivl_r == {DIV_W{1'b1}}) ? ivl_r : ivl_r + DIV_W'(1);
		est_nxt = est_r;
		est_ok_nxt = est_ok_r;
		seen_nxt = seen_r;
		if (!dat_pres) begin
			est_ok_nxt = 1'b0;
			seen_nxt = 1'b0;
		end
		if (dat_edge) begin
			ivl_nxt = DIV_W'(1);
			seen_nxt = 1'b1;
			if (seen_r && (!est_ok_r || ivl_r < est_r)) begin
				est_nxt = ivl_r;
				est_ok_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ivl_r <= '0;
			est_r <= '0;
			est_ok_r <= 1'b0;
			seen_r <= 1'b0;
		end else begin
			ivl_r <= ivl_nxt;
			est_r <= est_nxt;
			est_ok_r <= est_ok_nxt;
			seen_r <= seen_nxt;
		end
	end

	// ------------------------------------------------------------
	// bit strobe source
	// ------------------------------------------------------------
	// internal divider, measured rate or programmed rate
	assign period_sel = c_css ? iclk_div_r : (sel_auto ? est_r : br_div_r);
	assign gen_resync = sel_auto && dat_edge;

	txcds_bitgen #(
		.DIV_W(DIV_W)
	) u_bitgen (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.period_i(period_sel),
		.resync_i(gen_resync),
		.stb_o(gen_stb)
	);

	// ------------------------------------------------------------
	// internal data pattern
	// ------------------------------------------------------------
	// prbs9 and alternating pattern step only on internal bit strobes
	always_comb begin
		lfsr_nxt = lfsr_r;
		alt_nxt = alt_r;
		if (c_css && gen_stb) begin
			lfsr_nxt = {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
			alt_nxt = ~alt_r;
		end
		unique case (c_ids)
			TXCDS_IDS_ZERO: pat_bit = 1'b0;
			TXCDS_IDS_ONE: pat_bit = 1'b1;
			TXCDS_IDS_ALT: pat_bit = alt_r;
			TXCDS_IDS_PRBS: pat_bit = lfsr_r[8];
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			lfsr_r <= `TXCDS_RST_LFSR;
			alt_r <= 1'b0;
		end else begin
			lfsr_r <= lfsr_nxt;
			alt_r <= alt_nxt;
		end
	end

	// ------------------------------------------------------------
	// rf mode selection and bit output
	// ------------------------------------------------------------
	// re-decided every cycle from the current settings and presence
	always_comb begin
		mode_nxt = TXCDS_RF_OFF;
		if (c_rf) begin
			if (c_css) begin
				mode_nxt = TXCDS_RF_MOD;
			end else if (sel_manual) begin
				mode_nxt = TXCDS_RF_MOD;
			end else if (sel_auto) begin
				if (dat_pres && est_ok_r) begin
					mode_nxt = TXCDS_RF_MOD;
				end else begin
					mode_nxt = c_ace ? TXCDS_RF_CARRIER : TXCDS_RF_OFF;
				end
			end else begin
				if (clk_pres) begin
					mode_nxt = TXCDS_RF_MOD;
				end else begin
					mode_nxt = c_ace ? TXCDS_RF_CARRIER : TXCDS_RF_OFF;
				end
			end
		end
		rf_on_nxt = (mode_nxt != TXCDS_RF_OFF);
		mod_nxt = (mode_nxt == TXCDS_RF_MOD);
		tx_bit_nxt = tx_bit_r;
		stb_nxt = 1'b0;
		if (mode_nxt == TXCDS_RF_MOD) begin
			if (c_css) begin
				stb_nxt = gen_stb;
				tx_bit_nxt = gen_stb ? pat_bit : tx_bit_r;
			end else if (sel_extclk) begin
				stb_nxt = clk_rise;
				tx_bit_nxt = clk_rise ? dat_lvl : tx_bit_r;
			end else begin
				stb_nxt = gen_stb;
				tx_bit_nxt = gen_stb ? dat_lvl : tx_bit_r;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			mode_r <= TXCDS_RF_OFF;
			rf_on_r <= 1'b0;
			mod_r <= 1'b0;
			tx_bit_r <= 1'b0;
			stb_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			rf_on_r <= rf_on_nxt;
			mod_r <= mod_nxt;
			tx_bit_r <= tx_bit_nxt;
			stb_r <= stb_nxt;
		end
	end

	assign rf_mode_o = mode_r;
	assign rf_on_o = rf_on_r;
	assign modulate_o = mod_r;
	assign tx_bit_o = tx_bit_r;
	assign bit_strobe_o = stb_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_internal_only: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(c_rf && c_css) |=> (mode_r == TXCDS_RF_MOD && rf_on_o && modulate_o))
		else $error("internal clock source did not modulate");

	a_auto_mod: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(c_rf && sel_auto && dat_pres && est_ok_r) |=> (modulate_o && rf_on_o))
		else $error("auto rate with data present did not modulate");

	a_manual_mod: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(c_rf && sel_manual && !clk_pres && !dat_pres) |=> modulate_o)
		else $error("manual rate did not modulate without inputs");

	a_extclk_sample: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(c_rf && sel_extclk && clk_pres && clk_rise) |=> (bit_strobe_o && tx_bit_o == $past(dat_lvl)))
		else $error("external clock edge did not sample data");

	a_absent_off: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(c_rf && !c_ace && ((sel_extclk && !clk_pres) || (sel_auto && !dat_pres))) |=> (!rf_on_o && !bit_strobe_o))
		else $error("missing input with auto carrier off left rf on");

	a_absent_carrier: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(c_rf && c_ace && ((sel_extclk && !clk_pres) || (sel_auto && !dat_pres))) |=> (rf_on_o && !modulate_o))
		else $error("missing input with auto carrier on not held at carrier");

	a_rf_disabled: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!c_rf |=> (mode_r == TXCDS_RF_OFF && !rf_on_o && !bit_strobe_o))
		else $error("rf output active while disabled");
endmodule : txcds_top

//--- sim/txcds_src_model.sv
// external telemetry source: gated serial clock and a repeating 110 data pattern
`timescale 1ns/1ns
module txcds_src_model (
	input wire logic clk_en_i,
	input wire logic dat_en_i,
	output logic ext_clk_o,
	output logic ext_data_o,
	output logic last_bit_o
);
	logic [2:0] pat_r;

	// ------------------------------------------------------------
	// clock and data generation
	// ------------------------------------------------------------
	// free-running 320 ns timebase, phase offset from the system clock
	initial begin
		pat_r = 3'b110;
		ext_clk_o = 1'b0;
		ext_data_o = 1'b0;
		last_bit_o = 1'b0;
		#13;
		forever begin
			// the clock stands still low while gated off
			#160 ext_clk_o = clk_en_i;
			last_bit_o = ext_data_o;
			#160 ext_clk_o = 1'b0;
			// data moves on the falling half so it is steady at each rise
			if (dat_en_i) begin
				pat_r = {pat_r[1:0], pat_r[2]};
				ext_data_o = pat_r[2];
			end
		end
	end
endmodule : txcds_src_model

//--- sim/txcds_top_tb_top.sv
// testbench for the tx clock/data source selector
`timescale 1ns/1ns
`include "txcds_regs.svh"
module txcds_top_tb_top;
	import txcds_pkg::*;
	localparam int TMO = 24;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic clk_en = 1'b0, dat_en = 1'b0, ext_clk, ext_data, last_bit;
	logic rf_on, modulate, tx_bit, bit_strobe;
	txcds_rf_mode_t rf_mode;
	int n_mismatch = 0;
	int cmp_count = 0;

	always #20 clk_sys_i = ~clk_sys_i;

	txcds_top #(.DIV_W(16), .TIMEOUT_CYC(TMO)) dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
		.hready_i(hreadyout), .hreadyout_o(hreadyout), .hrdata_o(hrdata), .hresp_o(hresp),
		.ext_clk_i(ext_clk), .ext_data_i(ext_data), .rf_on_o(rf_on), .modulate_o(modulate),
		.tx_bit_o(tx_bit), .bit_strobe_o(bit_strobe), .rf_mode_o(rf_mode));

	txcds_src_model src_u (.clk_en_i(clk_en), .dat_en_i(dat_en), .ext_clk_o(ext_clk), .ext_data_o(ext_data),
		.last_bit_o(last_bit));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one single-word transfer; address phase held until hready is seen
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk_sys_i);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		ahb(1'b1, a, d, dummy);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		ahb(1'b0, a, 32'h00000000, d);
		check(d, exp);
	endtask : rdchk

	// wait a bounded time for the mode, then compare mode with rf_on and modulate
	task automatic mode_is(input txcds_rf_mode_t m, input int n);
		int i;
		for (i = 0; i < n && rf_mode !== m; i++) @(negedge clk_sys_i);
		check({28'h0, rf_mode, rf_on, modulate}, {28'h0, m, m != TXCDS_RF_OFF, m == TXCDS_RF_MOD});
	endtask : mode_is

	// count strobes over a window; sel 0/1 fixed bit, 2 bit from the source model
	task automatic strobes(input int cyc, input int sel, output int n, output int bad);
		n = 0;
		bad = 0;
		repeat (cyc) begin
			@(negedge clk_sys_i);
			if (bit_strobe === 1'b1) begin
				n++;
				if (tx_bit !== ((sel == 2) ? last_bit : sel[0])) bad++;
			end
		end
	endtask : strobes

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check({30'h0, hresp, hreadyout}, 32'h00000001);
		mode_is(TXCDS_RF_OFF, 1);
		rdchk(`TXCDS_OFF_CTRL, 32'h00000000);
		rdchk(`TXCDS_OFF_ICLK_DIV, 32'h00000010);
		rdchk(`TXCDS_OFF_BR_DIV, 32'h00000010);
		rdchk(8'h14, 32'h00000000);
		// every selector set but rf disabled: output stays off
		wr(`TXCDS_OFF_CTRL, 32'h000000FE);
		mode_is(TXCDS_RF_OFF, 5);
		$display("test reset done");
	endtask : t_reset

	task automatic t_internal();
		int n, bad;
		wr(`TXCDS_OFF_ICLK_DIV, 32'h00000004);
		// internal clock with internal data, ones pattern, ext lines dead
		wr(`TXCDS_OFF_CTRL, 32'h00000063);
		mode_is(TXCDS_RF_MOD, 5);
		repeat (8) @(negedge clk_sys_i);
		strobes(40, 1, n, bad);
		check(n, 10);
		check(bad, 0);
		// same clock, zeros pattern: every new bit must be a zero
		wr(`TXCDS_OFF_CTRL, 32'h00000023);
		repeat (8) @(negedge clk_sys_i);
		strobes(40, 0, n, bad);
		check(n, 10);
		check(bad, 0);
		$display("test internal done");
	endtask : t_internal

	task automatic t_manual();
		int n, bad;
		wr(`TXCDS_OFF_BR_DIV, 32'h00000005);
		wr(`TXCDS_OFF_CTRL, 32'h00000009);
		mode_is(TXCDS_RF_MOD, 5);
		repeat (8) @(negedge clk_sys_i);
		// data line is still quiet low, so every sampled bit is a zero
		strobes(50, 0, n, bad);
		check(n, 10);
		check(bad, 0);
		$display("test manual done");
	endtask : t_manual

	task automatic t_auto();
		int n, bad;
		wr(`TXCDS_OFF_CTRL, 32'h00000001);
		mode_is(TXCDS_RF_OFF, 5);
		wr(`TXCDS_OFF_CTRL, 32'h00000011);
		mode_is(TXCDS_RF_CARRIER, 5);
		@(posedge clk_sys_i);
		dat_en <= 1'b1;
		mode_is(TXCDS_RF_MOD, 120);
		rdchk(`TXCDS_OFF_RATE, 32'h00000008);
		rdchk(`TXCDS_OFF_STATUS, 32'h0000001A);
		// mid-bit strobes land after the source's own capture point
		strobes(80, 2, n, bad);
		check(n, 10);
		check(bad, 0);
		@(posedge clk_sys_i);
		dat_en <= 1'b0;
		mode_is(TXCDS_RF_CARRIER, TMO + 40);
		$display("test auto done");
	endtask : t_auto

	task automatic t_extclk();
		int n, bad;
		wr(`TXCDS_OFF_CTRL, 32'h00000005);
		mode_is(TXCDS_RF_OFF, 5);
		@(posedge clk_sys_i);
		clk_en <= 1'b1;
		dat_en <= 1'b1;
		mode_is(TXCDS_RF_MOD, 40);
		repeat (8) @(negedge clk_sys_i);
		strobes(80, 2, n, bad);
		check(n, 10);
		check(bad, 0);
		@(posedge clk_sys_i);
		clk_en <= 1'b0;
		mode_is(TXCDS_RF_OFF, TMO + 40);
		wr(`TXCDS_OFF_CTRL, 32'h00000015);
		mode_is(TXCDS_RF_CARRIER, 5);
		$display("test ext clock done");
	endtask : t_extclk

	// ------------------------------------------------------------
	// verdict and main sequence
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test

	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		n_mismatch++;
		stop_test();
	end

	initial begin
		repeat (2) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		@(negedge clk_sys_i);
		t_reset();
		t_internal();
		t_manual();
		t_auto();
		t_extclk();
		stop_test();
	end
endmodule : txcds_top_tb_top
